// ==== rtl/sfr_bank0.sv ====
// Bank-zero special function register bank behind an APB slave port.
// Assumes pins and reset-cause inputs are asynchronous; peripheral data same clock.
// Operation
// - Unimplemented bits and locations read as zero and ignore writes.
// - The upper program counter bits are reached only through a latch copied in on a low-byte load.
// - An external reset pin or watchdog timeout applies the non-power-up reset values.
// - The core registers decode at the same offset in every bank.
// - Unknown reset bits come up as a fixed value, unchanged bits keep contents, cause bits follow the cause.
// - Without brown-out detection the brown-out flag reads zero.
// - Without the fourth and fifth ports their data offsets read zero.
// - Power-on reset loads status with banks clear, timeout and power-down set.
module sfr_bank0
  import sfr_pkg::*;
#(
  parameter bit HAS_BROWNOUT = 1'b1, // Brown-out detection present
  parameter bit HAS_PORT_DE = 1'b1   // Fourth and fifth ports present
) (
  input  wire logic        pclk,             // Core clock
  input  wire logic        presetn,          // Power-on / brown-out reset, active low
  input  wire logic        psel,             // APB select
  input  wire logic        penable,          // APB enable
  input  wire logic        pwrite,           // APB direction
  input  wire logic [31:0] paddr,            // APB byte address
  input  wire logic [31:0] pwdata,           // APB write data
  output logic      [31:0] prdata,           // APB read data
  output logic             pready,           // APB ready
  output logic             pslverr,          // APB error, never set
  input  wire logic [5:0]  port_a_pin,       // Port A pin levels
  input  wire logic [7:0]  port_b_pin,       // Port B pin levels
  input  wire logic [7:0]  port_c_pin,       // Port C pin levels
  input  wire logic [7:0]  port_d_pin,       // Port D pin levels
  input  wire logic [2:0]  port_e_pin,       // Port E pin levels
  output logic      [5:0]  port_a_latch,     // Port A output latch
  output logic      [7:0]  port_b_latch,     // Port B output latch
  output logic      [7:0]  port_c_latch,     // Port C output latch
  output logic      [7:0]  port_d_latch,     // Port D output latch
  output logic      [2:0]  port_e_latch,     // Port E output latch
  input  wire logic        external_reset_pin_n, // External reset pin, active low
  input  wire logic        wdt_timeout,      // Watchdog timeout level
  input  wire logic        brownout_detect,  // Brown-out detector level
  input  wire logic [7:0]  usart_rx_data,    // Received USART byte
  input  wire logic [7:0]  adc_result_in,    // A/D conversion result
  output logic      [12:0] program_counter,  // Program counter as loaded
  output logic      [7:0]  core_status       // Status register contents
);

  typedef struct packed {
    logic [31:0][7:0] regs;      // Register storage by index
    logic [4:0]       pc_hi;     // Upper program counter bits
    logic [4:0][7:0]  pin_s1;    // Pin sampler stage one
    logic [4:0][7:0]  pin_s2;    // Pin sampler stage two
    logic [2:0]       ev_s1;     // Event sampler stage one
    logic [2:0]       ev_s2;     // Event sampler stage two
    logic             wdt_prev;  // Watchdog edge history
    logic             bor_flag;  // Sticky brown-out flag
    logic [31:0]      prdata;    // Read data for the access phase
    logic             pready;    // Access phase may complete
  } sfr_state_t;

  sfr_state_t q;
  sfr_state_t d;

  // Map a banked 9-bit index onto the bank-zero locations
  function automatic logic [5:0] map_loc(input logic [8:0] a);
    logic       ok;
    logic [4:0] i;
    ok = 1'b0;
    i  = a[4:0];
    if (a[6:5] == IN_MAP) begin
      ok = (a[8:BANK_LSB] == BANK_ZERO) || sfr_mirrored(i);
    end
    if (!HAS_PORT_DE && (i == IDX_PORT_D || i == IDX_PORT_E)) begin
      ok = 1'b0;
    end
    if (i == IDX_IND_PORT) begin
      ok = 1'b0;
    end
    return {ok, i};
  endfunction : map_loc

  // Read value of a mapped location
  function automatic logic [7:0] rd_loc(input logic [4:0] i);
    logic [7:0] v;
    v = q.regs[i];
    case (i)
      IDX_PORT_A:     v = q.pin_s2[PIN_A];
      IDX_PORT_B:     v = q.pin_s2[PIN_B];
      IDX_PORT_C:     v = q.pin_s2[PIN_C];
      IDX_PORT_D:     v = q.pin_s2[PIN_D];
      IDX_PORT_E:     v = q.pin_s2[PIN_E];
      IDX_RX_DATA:    v = usart_rx_data;
      IDX_ADC_RESULT: v = adc_result_in;
      default:   v = q.regs[i];
    endcase
    return v & sfr_attr(i).impl;
  endfunction : rd_loc

  logic [8:0] dir_idx;
  logic [8:0] ind_idx;
  logic [8:0] tgt_idx;
  logic [5:0] loc;
  logic       hit;
  logic [4:0] li;
  logic [7:0] wm;
  logic       setup_ph;
  logic       write_ph;
  logic       ext_rst;
  logic       wdt_rst;

  // Decode, register update and reset-cause handling
  always_comb begin
    d = q;
    dir_idx  = paddr[ADDR_MSB:ADDR_LSB];
    ind_idx  = {q.regs[IDX_STATUS][ST_IND_BANK], q.regs[IDX_IND_PTR]};
    // Indirect access goes through the pointer; the port itself holds nothing
    tgt_idx  = (map_loc(dir_idx) == {1'b0, IDX_IND_PORT}) && (dir_idx[6:5] == IN_MAP) &&
               (dir_idx[8:BANK_LSB] == BANK_ZERO || sfr_mirrored(IDX_IND_PORT)) ?
               ind_idx : dir_idx;
    loc      = map_loc(tgt_idx);
    hit      = loc[5];
    li       = loc[4:0];
    wm       = sfr_attr(li).wr;
    setup_ph = psel && !penable;
    write_ph = psel && penable && q.pready && pwrite;

    // Two-stage samplers; stage one feeds only stage two
    d.pin_s1[PIN_A] = {2'h0, port_a_pin};
    d.pin_s1[PIN_B] = port_b_pin;
    d.pin_s1[PIN_C] = port_c_pin;
    d.pin_s1[PIN_D] = port_d_pin;
    d.pin_s1[PIN_E] = {5'h00, port_e_pin};
    d.pin_s2        = q.pin_s1;
    d.ev_s1         = {brownout_detect, wdt_timeout, external_reset_pin_n};
    d.ev_s2         = q.ev_s1;
    d.wdt_prev      = q.ev_s2[EV_WDT];
    ext_rst         = !q.ev_s2[EV_EXT_N];
    wdt_rst         = q.ev_s2[EV_WDT] && !q.wdt_prev;

    // Read data is captured in setup so the access phase ends at once
    d.pready = setup_ph;
    if (setup_ph) begin
      if (dir_idx == IDX_CAUSE) begin
        d.prdata = {31'h0, q.bor_flag & HAS_BROWNOUT};
      end else if (hit) begin
        d.prdata = {24'h0, rd_loc(li)};
      end else begin
        d.prdata = 32'h0;
      end
    end

    // Register writes, masked to the writable bits
    if (write_ph && hit) begin
      d.regs[li] = (q.regs[li] & ~wm) | (pwdata[7:0] & wm);
      if (li == IDX_PC_LOW) begin
        d.pc_hi = q.regs[IDX_PC_LATCH][4:0];
      end
    end

    // Brown-out flag: write one clears, a new detection wins
    if (write_ph && dir_idx == IDX_CAUSE && pwdata[CAUSE_BROWNOUT]) begin
      d.bor_flag = 1'b0;
    end
    if (q.ev_s2[EV_BROWNOUT] && HAS_BROWNOUT) begin
      d.bor_flag = 1'b1;
    end

    // Non-power-up reset overrides any register write in the same cycle, but not a brown-out flag clear
    if (ext_rst || wdt_rst) begin
      for (int k = 0; k < 32; k++) begin
        d.regs[k] = q.regs[k] & sfr_attr(k[4:0]).keep;
      end
      // Timeout depends on the cause; power-down keeps its value
      d.regs[IDX_STATUS][ST_PWR_DOWN] = q.regs[IDX_STATUS][ST_PWR_DOWN];
      d.regs[IDX_STATUS][ST_TIMEOUT] = wdt_rst ? 1'b0 : q.regs[IDX_STATUS][ST_TIMEOUT];
      d.pc_hi = 5'h00;
    end
  end

  // State register; power-on reset loads the power-up column
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q                  <= '0;
      q.regs[IDX_STATUS] <= POR_STATUS;
      q.ev_s1            <= EV_IDLE;
      q.ev_s2            <= EV_IDLE;
    end else begin
      q <= d;
    end
  end

  // Outputs other than pslverr straight from the state register; pslverr is tied low
  assign prdata          = q.prdata;
  assign pready          = q.pready;
  assign pslverr         = 1'b0;
  assign port_a_latch    = q.regs[IDX_PORT_A][5:0];
  assign port_b_latch    = q.regs[IDX_PORT_B];
  assign port_c_latch    = q.regs[IDX_PORT_C];
  assign port_d_latch    = q.regs[IDX_PORT_D];
  assign port_e_latch    = q.regs[IDX_PORT_E][2:0];
  assign program_counter = {q.pc_hi, q.regs[IDX_PC_LOW]};
  assign core_status     = q.regs[IDX_STATUS];

endmodule : sfr_bank0

// ==== rtl/sfr_pkg.sv ====
// Constants for the bank-zero special function register bank.
// Assumes word-wide APB access; each register index sits at byte address index*4.
package sfr_pkg;

  // Register indices (byte address is four times the index)
  localparam logic [4:0] IDX_IND_PORT   = 5'h00;
  localparam logic [4:0] IDX_T0_COUNT   = 5'h01;
  localparam logic [4:0] IDX_PC_LOW     = 5'h02;
  localparam logic [4:0] IDX_STATUS     = 5'h03;
  localparam logic [4:0] IDX_IND_PTR    = 5'h04;
  localparam logic [4:0] IDX_PORT_A     = 5'h05;
  localparam logic [4:0] IDX_PORT_B     = 5'h06;
  localparam logic [4:0] IDX_PORT_C     = 5'h07;
  localparam logic [4:0] IDX_PORT_D     = 5'h08;
  localparam logic [4:0] IDX_PORT_E     = 5'h09;
  localparam logic [4:0] IDX_PC_LATCH   = 5'h0a;
  localparam logic [4:0] IDX_INT_CTRL   = 5'h0b;
  localparam logic [4:0] IDX_FLAGS_ONE  = 5'h0c;
  localparam logic [4:0] IDX_FLAGS_TWO  = 5'h0d;
  localparam logic [4:0] IDX_T1_LOW     = 5'h0e;
  localparam logic [4:0] IDX_T1_HIGH    = 5'h0f;
  localparam logic [4:0] IDX_T1_CTRL    = 5'h10;
  localparam logic [4:0] IDX_T2_COUNT   = 5'h11;
  localparam logic [4:0] IDX_T2_CTRL    = 5'h12;
  localparam logic [4:0] IDX_SER_BUF    = 5'h13;
  localparam logic [4:0] IDX_SER_CTRL   = 5'h14;
  localparam logic [4:0] IDX_CC1_LOW    = 5'h15;
  localparam logic [4:0] IDX_CC1_HIGH   = 5'h16;
  localparam logic [4:0] IDX_CC1_CTRL   = 5'h17;
  localparam logic [4:0] IDX_RX_STATUS  = 5'h18;
  localparam logic [4:0] IDX_TX_DATA    = 5'h19;
  localparam logic [4:0] IDX_RX_DATA    = 5'h1a;
  localparam logic [4:0] IDX_CC2_LOW    = 5'h1b;
  localparam logic [4:0] IDX_CC2_HIGH   = 5'h1c;
  localparam logic [4:0] IDX_CC2_CTRL   = 5'h1d;
  localparam logic [4:0] IDX_ADC_RESULT = 5'h1e;
  localparam logic [4:0] IDX_ADC_CTRL   = 5'h1f;

  // Reset-cause register, outside the printed map
  localparam logic [8:0] IDX_CAUSE      = 9'h020;
  localparam int         CAUSE_BROWNOUT = 0;

  // Core status fields and reset values
  localparam int         ST_IND_BANK = 7;
  localparam int         ST_TIMEOUT  = 4;
  localparam int         ST_PWR_DOWN = 3;
  localparam logic [7:0] POR_STATUS  = 8'h18;
  localparam logic [7:0] STATUS_WR   = 8'he7;
  localparam logic [7:0] STATUS_KEEP = 8'h07;

  // Synchronised event inputs
  localparam int         EV_EXT_N    = 0;
  localparam int         EV_WDT      = 1;
  localparam int         EV_BROWNOUT = 2;
  localparam logic [2:0] EV_IDLE     = 3'h1;

  // Port numbers in the pin sampler
  localparam int         PIN_A       = 0;
  localparam int         PIN_B       = 1;
  localparam int         PIN_C       = 2;
  localparam int         PIN_D       = 3;
  localparam int         PIN_E       = 4;

  // Address split of the 9-bit register index
  localparam int         ADDR_LSB    = 2;
  localparam int         ADDR_MSB    = 10;
  localparam int         BANK_LSB    = 7;
  localparam logic [1:0] BANK_ZERO   = 2'h0;
  localparam logic [1:0] IN_MAP      = 2'h0;

  typedef struct packed {
    logic [7:0] impl;  // Implemented bits, read mask
    logic [7:0] keep;  // Bits left unchanged by non-power-up resets
    logic [7:0] wr;    // Bits software may write
  } sfr_attr_t;

  // Per-register masks; unlisted bits read zero
  function automatic sfr_attr_t sfr_attr(input logic [4:0] i);
    sfr_attr_t a;
    a = '{impl: 8'hff, keep: 8'h00, wr: 8'hff};
    case (i)
      IDX_IND_PORT:  a = '{impl: 8'h00, keep: 8'h00, wr: 8'h00};
      IDX_STATUS:    a = '{impl: 8'hff, keep: STATUS_KEEP, wr: STATUS_WR};
      IDX_PORT_A:    a = '{impl: 8'h3f, keep: 8'h10, wr: 8'h3f};
      IDX_PORT_E:    a = '{impl: 8'h07, keep: 8'h07, wr: 8'h07};
      IDX_PC_LATCH:  a = '{impl: 8'h1f, keep: 8'h00, wr: 8'h1f};
      IDX_INT_CTRL:  a = '{impl: 8'hff, keep: 8'h01, wr: 8'hff};
      IDX_FLAGS_TWO: a = '{impl: 8'h01, keep: 8'h00, wr: 8'h01};
      IDX_T1_CTRL:   a = '{impl: 8'h3f, keep: 8'h3f, wr: 8'h3f};
      IDX_T2_CTRL:   a = '{impl: 8'h7f, keep: 8'h00, wr: 8'h7f};
      IDX_CC1_CTRL,
      IDX_CC2_CTRL:  a = '{impl: 8'h3f, keep: 8'h00, wr: 8'h3f};
      IDX_RX_STATUS: a = '{impl: 8'hf7, keep: 8'h01, wr: 8'hf7};
      IDX_TX_DATA:   a = '{impl: 8'h00, keep: 8'h00, wr: 8'hff};
      IDX_RX_DATA,
      IDX_ADC_RESULT: a = '{impl: 8'hff, keep: 8'h00, wr: 8'h00};
      IDX_ADC_CTRL:  a = '{impl: 8'hfd, keep: 8'h00, wr: 8'hfd};
      IDX_T0_COUNT, IDX_IND_PTR, IDX_PORT_B, IDX_PORT_C, IDX_PORT_D, IDX_T1_LOW,
      IDX_T1_HIGH, IDX_SER_BUF, IDX_CC1_LOW, IDX_CC1_HIGH, IDX_CC2_LOW, IDX_CC2_HIGH:
                     a = '{impl: 8'hff, keep: 8'hff, wr: 8'hff};
      default:     a = '{impl: 8'hff, keep: 8'h00, wr: 8'hff};
    endcase
    return a;
  endfunction : sfr_attr

  // Core registers decoded in every bank
  function automatic logic sfr_mirrored(input logic [4:0] i);
    return (i == IDX_IND_PORT) || (i == IDX_PC_LOW) || (i == IDX_STATUS) ||
           (i == IDX_IND_PTR) || (i == IDX_PC_LATCH) || (i == IDX_INT_CTRL);
  endfunction : sfr_mirrored

endpackage : sfr_pkg

// ==== sim/sfr_bank0_sva.sv ====
// Checker for the bank-zero register file, watching only top-level ports.
// Assumes one clock domain and the zero-wait-state APB answer of the slave.
module sfr_bank0_sva
  import sfr_pkg::*;
(
  input wire logic        pclk,            // Core clock
  input wire logic        presetn,         // Reset, active low
  input wire logic        psel,            // APB select
  input wire logic        penable,         // APB enable
  input wire logic        pwrite,          // APB direction
  input wire logic [31:0] paddr,           // APB address
  input wire logic [31:0] pwdata,          // APB write data
  input wire logic [31:0] prdata,          // APB read data
  input wire logic        pready,          // APB ready
  input wire logic        pslverr,         // APB error
  input wire logic [7:0]  port_b_latch,    // Port B latch
  input wire logic [12:0] program_counter, // Loaded counter
  input wire logic [7:0]  core_status      // Status contents
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Decoded index and completed access
  logic [8:0] idx;
  logic       acc;
  assign idx = paddr[10:2];
  assign acc = psel && penable && pready;

  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("ready missing after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_no_error: assert property (pready |-> !pslverr)
    else $error("unexpected slave error");
  a_upper_zero: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_latch_mask: assert property (acc && !pwrite && idx[6:0] == {2'h0, IDX_PC_LATCH} |-> prdata[7:5] == 3'h0)
    else $error("latch spare bits not zero");
  a_tx_data_zero: assert property (acc && !pwrite && idx == {4'h0, IDX_TX_DATA} |-> prdata == 32'h0)
    else $error("transmit data readable");
  a_bank_unmirror: assert property (acc && !pwrite && idx[8:7] != 2'h0 && idx[6:0] == 7'h05 |-> prdata == 32'h0)
    else $error("unmirrored offset decoded");
  a_pc_load: assert property (acc && pwrite && idx[6:0] == {2'h0, IDX_PC_LOW} |=> program_counter[7:0] == $past(pwdata[7:0]))
    else $error("counter low byte not loaded");
  a_latch_write: assert property (acc && pwrite && idx == {4'h0, IDX_PORT_B} |=> port_b_latch == $past(pwdata[7:0]))
    else $error("port latch not written");
  a_por_status: assert property ($rose(presetn) |-> core_status == POR_STATUS)
    else $error("status wrong after power-on");
endmodule : sfr_bank0_sva

bind sfr_bank0 sfr_bank0_sva i_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .port_b_latch(port_b_latch),
  .program_counter(program_counter), .core_status(core_status));

// ==== sim/sfr_bank0_tb_top.sv ====
// Self-checking bench for the bank-zero register file over APB.
// Assumes the hand-over timing: zero wait states, two-flop pin and event sync.
module sfr_bank0_tb_top;
  import sfr_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rdat;
  logic        pready, pslverr, ext_n = 1'b1, wdt = 1'b0, bod = 1'b0;
  logic [5:0]  pa = 6'h0;
  logic [7:0]  pb = 8'h0, pc = 8'h0, pd = 8'h0, rx = 8'h0, adc = 8'h0, lb;
  logic [2:0]  pe = 3'h0, le;
  logic [5:0]  la;
  logic [7:0]  lc, ld;
  logic [12:0] pcnt;
  logic [7:0]  st;
  int          n_errors = 0, check_count = 0;

  sfr_bank0 i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port_a_pin(pa), .port_b_pin(pb), .port_c_pin(pc), .port_d_pin(pd),
    .port_e_pin(pe), .port_a_latch(la), .port_b_latch(lb), .port_c_latch(lc),
    .port_d_latch(ld), .port_e_latch(le), .external_reset_pin_n(ext_n), .wdt_timeout(wdt),
    .brownout_detect(bod),
    .usart_rx_data(rx), .adc_result_in(adc), .program_counter(pcnt), .core_status(st));

  // Free-running 25 MHz clock
  always #20 pclk = ~pclk;

  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One APB transfer; request held until ready is sampled high, hang left to watchdog
  task automatic apb(input logic w, input logic [8:0] idx, input logic [7:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {21'h0, idx, 2'h0};
    pwdata  <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [8:0] idx, input logic [7:0] wd);
    apb(1'b1, idx, wd);
  endtask : wr

  task automatic rd(input string what, input logic [8:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h0);
    chk(what, {24'h0, exp}, rdat);
  endtask : rd

  // Main sequence
  initial begin
    repeat (4) @(posedge pclk);
    chk("status_por", 32'h18, {24'h0, st});
    presetn <= 1'b1;
    rd("status_rd", {4'h0, IDX_STATUS}, 8'h18);
    $display("reset test done");
    wr({4'h0, IDX_PC_LATCH}, 8'hff);
    rd("latch_mask", {4'h0, IDX_PC_LATCH}, 8'h1f);
    wr({4'h0, IDX_FLAGS_TWO}, 8'hff);
    rd("flags2_mask", {4'h0, IDX_FLAGS_TWO}, 8'h01);
    wr({4'h0, IDX_TX_DATA}, 8'h55);
    rd("tx_data", {4'h0, IDX_TX_DATA}, 8'h00);
    rd("unmapped", 9'h040, 8'h00);
    wr({4'h0, IDX_STATUS}, 8'h27);
    rd("status_wr", {4'h0, IDX_STATUS}, 8'h3f);
    $display("mask test done");
    wr({4'h0, IDX_PC_LATCH}, 8'h15);
    wr({4'h0, IDX_PC_LOW}, 8'h34);
    @(negedge pclk);
    chk("pc_load", 32'h1534, {19'h0, pcnt});
    rd("mirror_status", 9'h083, 8'h3f);
    rd("mirror_pc_upper_latch", 9'h18a, 8'h15);
    rd("bank1_port_a_data", 9'h085, 8'h00);
    $display("pc and mirror test done");
    pa <= 6'h2a;
    pb <= 8'h3c;
    pd <= 8'hc3;
    pe <= 3'h5;
    rx <= 8'h6e;
    adc <= 8'h91;
    wr({4'h0, IDX_PORT_B}, 8'ha5);
    @(negedge pclk);
    chk("latch_b", 32'ha5, {24'h0, lb});
    wr({4'h0, IDX_PORT_A}, 8'hff);
    wr({4'h0, IDX_PORT_C}, 8'h5a);
    wr({4'h0, IDX_PORT_D}, 8'h96);
    wr({4'h0, IDX_PORT_E}, 8'hff);
    @(negedge pclk);
    chk("latch_a", 32'h3f, {26'h0, la});
    chk("latch_c", 32'h5a, {24'h0, lc});
    chk("latch_d", 32'h96, {24'h0, ld});
    chk("latch_e", 32'h07, {29'h0, le});
    rd("pins_b", {4'h0, IDX_PORT_B}, 8'h3c);
    rd("pins_a", {4'h0, IDX_PORT_A}, 8'h2a);
    rd("pins_d", {4'h0, IDX_PORT_D}, 8'hc3);
    rd("pins_e", {4'h0, IDX_PORT_E}, 8'h05);
    rd("rx_data", {4'h0, IDX_RX_DATA}, 8'h6e);
    wr({4'h0, IDX_ADC_RESULT}, 8'h00);
    rd("adc_ro", {4'h0, IDX_ADC_RESULT}, 8'h91);
    $display("port test done");
    bod <= 1'b1;
    repeat (4) @(posedge pclk);
    bod <= 1'b0;
    rd("bor_flag", IDX_CAUSE, 8'h01);
    wr(IDX_CAUSE, 8'h01);
    rd("bor_clear", IDX_CAUSE, 8'h00);
    $display("brown-out test done");
    wr({4'h0, IDX_IND_PTR}, 8'h5a);
    wr({4'h0, IDX_FLAGS_ONE}, 8'h7f);
    ext_n <= 1'b0;
    repeat (8) @(posedge pclk);
    ext_n <= 1'b1;
    repeat (8) @(posedge pclk);
    chk("pc_other", 32'h0, {19'h0, pcnt});
    rd("ptr_kept", {4'h0, IDX_IND_PTR}, 8'h5a);
    rd("flags1_clr", {4'h0, IDX_FLAGS_ONE}, 8'h00);
    rd("status_ext", {4'h0, IDX_STATUS}, 8'h1f);
    wdt <= 1'b1;
    repeat (8) @(posedge pclk);
    wdt <= 1'b0;
    repeat (8) @(posedge pclk);
    rd("status_wdt", {4'h0, IDX_STATUS}, 8'h0f);
    $display("other reset test done");
    summarize();
  end

  // Hang guard, far beyond the 150 or so cycles the tests need
  initial begin
    repeat (5000) @(posedge pclk);
    n_errors++;
    summarize();
  end
endmodule : sfr_bank0_tb_top
